// >>> hdl/tsr_readout.sv
// temperature value and status flag readout behind the register port
//
// Overview of operation
// - power-on reset clears backup switch flag
// - modes 00 and 11 hold flag zero
// - high byte read-only, writes ignored
// - high byte is signed integer bits 11:4
// - low byte: fraction, fail, busy, clock, backup
`timescale 1ns/1ps
`default_nettype none

module tsr_readout (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire tsr_pkg::tsr_reg_req_t   reg_req,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic [11:0]             temp_value,
  input  wire logic                    temp_update,
  input  wire tsr_pkg::tsr_ext_flags_t ext_flags,
  input  wire logic [1:0]              backup_switch_mode_field,
  input  wire logic                    switchover_async,
  output logic                         backup_switch_flag,
  output logic [11:0]                  temp_current
);

  logic [11:0] temp_reg;
  logic [11:0] temp_next;
  logic        bsf_reg;
  logic        bsf_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic        switch_rise;
  logic        mode_enabled;
  logic        bsf_visible;
  logic [7:0]  low_byte;
  logic [7:0]  high_byte;

  // switchover indication comes from the supply monitor, another domain
  tsr_event_sync u_switch_sync (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .async_in   (switchover_async),
    .level_out  (),
    .rise_pulse (switch_rise)
  );

  // true when the mode code leaves switchover enabled
  function automatic logic tsr_mode_on(input logic [1:0] mode);
    tsr_mode_on = (mode != tsr_pkg::TSR_BSM_OFF_A) && (mode != tsr_pkg::TSR_BSM_OFF_B);
  endfunction

  assign mode_enabled = tsr_mode_on(backup_switch_mode_field);

  // flag gated by mode
  // gating the view too covers the cycle in which the mode just turned off
  assign bsf_visible = bsf_reg & mode_enabled;

  assign low_byte = {temp_reg[tsr_pkg::TSR_FRAC_MSB-4:tsr_pkg::TSR_FRAC_LSB-4],
                     ext_flags.eeprom_fail_flag,
                     ext_flags.eeprom_busy_flag,
                     ext_flags.clock_output_int_flag,
                     bsf_visible};

  // integer part with sign in bit 7
  assign high_byte = temp_reg[tsr_pkg::TSR_INT_MSB:tsr_pkg::TSR_INT_LSB];

  // temperature holding register; no shadowing between the two bytes
  always_comb begin
    temp_next = temp_reg;
    if (temp_update) begin
      temp_next = temp_value;
    end
  end

  // backup switch flag next value
  always_comb begin
    bsf_next = bsf_reg;
    if (reg_req.wr && (reg_req.addr == tsr_pkg::TSR_ADDR_TEMP_LOW)
        && !reg_req.wdata[tsr_pkg::TSR_BSF_BIT]) begin
      bsf_next = 1'b0;
    end
    if (switch_rise) begin
      bsf_next = 1'b1;
    end
    if (!mode_enabled) begin
      bsf_next = 1'b0;
    end
  end

  // read data path, one cycle after the read strobe
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_req.rd;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        tsr_pkg::TSR_ADDR_TEMP_LOW:  rdata_next = low_byte;
        tsr_pkg::TSR_ADDR_TEMP_HIGH: rdata_next = high_byte;
        default:                     rdata_next = tsr_pkg::TSR_UNMAPPED;
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      temp_reg   <= tsr_pkg::TSR_TEMP_RST;
      bsf_reg    <= tsr_pkg::TSR_BSF_RST;
      rdata_reg  <= tsr_pkg::TSR_RDATA_RST;
      rvalid_reg <= 1'b0;
    end else begin
      temp_reg   <= temp_next;
      bsf_reg    <= bsf_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata          = rdata_reg;
  assign reg_rvalid         = rvalid_reg;
  assign backup_switch_flag = bsf_visible;
  assign temp_current       = temp_reg;

  // ---------------- assertions ----------------

  sequence s_read_high;
    reg_req.rd && (reg_req.addr == tsr_pkg::TSR_ADDR_TEMP_HIGH);
  endsequence

  sequence s_read_low;
    reg_req.rd && (reg_req.addr == tsr_pkg::TSR_ADDR_TEMP_LOW);
  endsequence

  sequence s_clear_write;
    reg_req.wr && (reg_req.addr == tsr_pkg::TSR_ADDR_TEMP_LOW)
      && !reg_req.wdata[0] && !switch_rise;
  endsequence

  a_por_flag_clear: assert property (@(posedge sys_clk)
    srst |=> !bsf_reg)
    else $error("backup switch flag not cleared by reset");

  a_mode_off_zero: assert property (@(posedge sys_clk) disable iff (srst)
    !mode_enabled |-> !backup_switch_flag ##1 (!bsf_reg))
    else $error("backup switch flag set while switchover disabled");

  a_high_read_only: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_req.wr && (reg_req.addr == tsr_pkg::TSR_ADDR_TEMP_HIGH) && !temp_update)
      |=> $stable(temp_reg))
    else $error("write changed the temperature value");

  a_high_byte_map: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_high |=> reg_rvalid && (reg_rdata == $past(temp_reg[11:4])))
    else $error("high byte does not carry integer bits");

  a_low_byte_map: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_low |=> reg_rvalid && (reg_rdata == {$past(temp_reg[3:0]),
      $past(ext_flags.eeprom_fail_flag), $past(ext_flags.eeprom_busy_flag),
      $past(ext_flags.clock_output_int_flag), $past(bsf_visible)}))
    else $error("low byte layout wrong");

  a_switch_sets_flag: assert property (@(posedge sys_clk) disable iff (srst)
    (switch_rise && mode_enabled) |=> bsf_reg)
    else $error("switchover did not set flag");

  a_zero_clears_flag: assert property (@(posedge sys_clk) disable iff (srst)
    s_clear_write |=> !bsf_reg)
    else $error("zero write did not clear flag");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_req.rd && (reg_req.addr != tsr_pkg::TSR_ADDR_TEMP_LOW)
      && (reg_req.addr != tsr_pkg::TSR_ADDR_TEMP_HIGH))
      |=> reg_rvalid && (reg_rdata == tsr_pkg::TSR_UNMAPPED))
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

// >>> inc/tsr_pkg.sv
// constants and carrier types for the temperature and status readout
package tsr_pkg;

  // register byte addresses on the internal register port
  localparam logic [7:0] TSR_ADDR_TEMP_LOW  = 8'h0E;
  localparam logic [7:0] TSR_ADDR_TEMP_HIGH = 8'h0F;

  // widths
  localparam int unsigned TSR_TEMP_W = 12;
  localparam int unsigned TSR_DATA_W = 8;

  // field positions in the low byte
  localparam int unsigned TSR_FRAC_MSB     = 7;
  localparam int unsigned TSR_FRAC_LSB     = 4;
  localparam int unsigned TSR_EEF_BIT      = 3;
  localparam int unsigned TSR_EEPROM_BUSY_FLAG_BIT   = 2;
  localparam int unsigned TSR_CLOCK_OUTPUT_INT_FLAG_BIT     = 1;
  localparam int unsigned TSR_BSF_BIT      = 0;

  // field positions of the integer part inside the 12-bit value
  localparam int unsigned TSR_INT_MSB      = 11;
  localparam int unsigned TSR_INT_LSB      = 4;

  // switchover mode codes that disable switchover
  localparam logic [1:0] TSR_BSM_OFF_A = 2'h0;
  localparam logic [1:0] TSR_BSM_OFF_B = 2'h3;

  // reset values
  localparam logic [11:0] TSR_TEMP_RST  = 12'h000;
  localparam logic        TSR_BSF_RST   = 1'b0;
  localparam logic [7:0]  TSR_RDATA_RST = 8'h00;
  localparam logic [7:0]  TSR_UNMAPPED  = 8'h00;

  // synchroniser depth
  localparam int unsigned TSR_SYNC_STAGES = 3;

  // one register access from the serial interface logic
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsr_reg_req_t;

  // flags driven by neighbouring engines
  typedef struct packed {
    logic eeprom_fail_flag;
    logic eeprom_busy_flag;
    logic clock_output_int_flag;
  } tsr_ext_flags_t;

endpackage

// >>> hdl/tsr_event_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module tsr_event_sync (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_pulse
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       level_reg;
  logic       level_next;
  logic       rise_reg;
  logic       rise_next;

  // the first stage feeds only the second; stages two and three vote
  always_comb begin
    stage_next = {stage_reg[1:0], async_in};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
    rise_next = level_next & ~level_reg;
  end

  // registers only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
      rise_reg  <= rise_next;
    end
  end

  assign level_out  = level_reg;
  assign rise_pulse = rise_reg;

endmodule
`default_nettype wire

// >>> testbench/tsr_host_model.sv
// host-side register access model for the readout block
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
  input  wire logic                   sys_clk,
  output var  tsr_pkg::tsr_reg_req_t  reg_req,
  input  wire logic [7:0]             reg_rdata,
  input  wire logic                   reg_rvalid
);
  initial reg_req = '0;
  // one access, held until its taking edge; read data lands with rvalid
  task automatic acc(input logic r, input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #1 reg_req = {r, w, a, d};
    @(posedge sys_clk);
    #1 reg_req = '0;
    q = (r && reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask
  // read the high byte before and after the low byte and compare, the bytes are not shadowed
  task automatic read_temp(output logic [11:0] v);
    logic [7:0] h1, h2, l;
    acc(1'b1, 1'b0, tsr_pkg::TSR_ADDR_TEMP_HIGH, 8'h00, h1);
    acc(1'b1, 1'b0, tsr_pkg::TSR_ADDR_TEMP_LOW, 8'h00, l);
    acc(1'b1, 1'b0, tsr_pkg::TSR_ADDR_TEMP_HIGH, 8'h00, h2);
    // signed value counts sixteenths of a degree
    v = (h1 === h2) ? {h1, l[7:4]} : 'x;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tsr_readout_tb.sv
// self-checking bench for the temperature and status readout
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_tb;
  logic                    sys_clk = 1'b0;
  logic                    srst = 1'b1;
  tsr_pkg::tsr_reg_req_t   reg_req;
  logic [7:0]              reg_rdata;
  logic                    reg_rvalid;
  logic [11:0]             temp_value = 12'h000;
  logic                    temp_update = 1'b0;
  tsr_pkg::tsr_ext_flags_t ext_flags = 3'h5;
  logic [1:0]              mode = 2'h1;
  logic                    sw_async = 1'b0;
  logic                    backup_switch_flag;
  logic [11:0]             temp_current;
  logic [7:0]              q;
  logic [11:0]             t;
  integer fails = 0, cmp_count = 0, seed = 32'h3CCA, m_temp = 0, m_bsf = 0, i, k;
  int tq[$] = '{12'h7FF, 12'h800, 12'hFFF, 12'h004};

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  tsr_readout i_tsr_readout (.sys_clk(sys_clk), .srst(srst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temp_value(temp_value),
    .temp_update(temp_update), .ext_flags(ext_flags),
    .backup_switch_mode_field(mode), .switchover_async(sw_async),
    .backup_switch_flag(backup_switch_flag), .temp_current(temp_current));
  tsr_host_model i_tsr_host_model (.sys_clk(sys_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // both bytes against the model
  task automatic chk_regs;
    i_tsr_host_model.acc(1'b1, 1'b0, tsr_pkg::TSR_ADDR_TEMP_HIGH, 8'h00, q);
    chk("high", 12'((m_temp >> 4) & 255), {4'h0, q});
    i_tsr_host_model.acc(1'b1, 1'b0, tsr_pkg::TSR_ADDR_TEMP_LOW, 8'h00, q);
    chk("low", 12'((m_temp & 15) * 16 + int'(ext_flags) * 2 + m_bsf), {4'h0, q});
  endtask
  // async rise, then a bounded wait for the visible flag
  task automatic switch_over;
    @(posedge sys_clk);
    #1 sw_async = 1'b1;
    // look just after each edge so the registered flag has settled
    for (k = 0; k < 12 && backup_switch_flag !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    sw_async = 1'b0;
    chk("flag", 12'(m_bsf), {11'h0, backup_switch_flag});
    if (m_bsf == 1 && k == 12) test_done;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    chk("temp_rst", 12'h000, temp_current);
    chk_regs;
    i_tsr_host_model.acc(1'b1, 1'b0, 8'h10, 8'h00, q);
    chk("unmapped", 12'h000, {4'h0, q});
    // table corners first, then random readings
    for (i = 0; i < 12; i++) begin
      t = (i < 4) ? 12'(tq[i]) : 12'($random(seed));
      @(posedge sys_clk);
      #1 temp_value = t;
      temp_update = 1'b1;
      ext_flags = 3'($random(seed));
      @(posedge sys_clk);
      #1 temp_update = 1'b0;
      m_temp = t;
      chk("temp_cur", t, temp_current);
      i_tsr_host_model.acc(1'b0, 1'b1, tsr_pkg::TSR_ADDR_TEMP_HIGH, 8'($random(seed)), q);
      chk_regs;
      i_tsr_host_model.read_temp(t);
      chk("temp_rd", 12'(m_temp), t);
    end
    // every mode code, then write one and write zero
    for (i = 0; i < 4; i++) begin
      mode = 2'(i);
      m_bsf = (i == 1 || i == 2);
      switch_over;
      chk_regs;
      i_tsr_host_model.acc(1'b0, 1'b1, tsr_pkg::TSR_ADDR_TEMP_LOW, 8'hFF, q);
      chk_regs;
      i_tsr_host_model.acc(1'b0, 1'b1, tsr_pkg::TSR_ADDR_TEMP_LOW, 8'h00, q);
      m_bsf = 0;
      chk_regs;
    end
    // second reset with the flag set
    mode = 2'h2;
    m_bsf = 1;
    switch_over;
    @(posedge sys_clk);
    #1 srst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 srst = 1'b0;
    m_bsf = 0;
    m_temp = 0;
    chk("flag_rst", 12'h000, {11'h0, backup_switch_flag});
    chk_regs;
    test_done;
  end
endmodule
`default_nettype wire
